// ---- hdl/stepper_drive_pkg.sv ----
package stepper_drive_pkg;

    // Bus register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] POSITION_OFFSET = 8'h08;

    // Control register fields
    localparam int CTRL_REDUCE_BIT = 0;
    localparam int CTRL_DIR_SWAP_BIT = 1;
    localparam int CTRL_STEP_SWAP_BIT = 2;
    localparam int CTRL_MONITOR_ON_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h9;

    // Status register fields
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_FOLLOW_BIT = 1;
    localparam int STAT_OVERHEAT_BIT = 2;
    localparam int STAT_RINGZERO_BIT = 3;
    localparam int STAT_HALF_BIT = 4;
    localparam int STAT_BOOST_BIT = 5;
    localparam int STAT_STANDSTILL_BIT = 6;
    localparam int STAT_FAULT_BIT = 7;

    // Clock and times
    localparam int CLK_HZ = 40000000;
    localparam int READY_DELAY_MS = 1500;
    localparam int READY_DELAY_CYCLES = CLK_HZ / 1000 * READY_DELAY_MS;
    localparam int STANDSTILL_HZ = 10;
    localparam int STANDSTILL_CYCLES = CLK_HZ / STANDSTILL_HZ;

    // Motion figures
    localparam int HALF_STEPS_PER_REV = 1000;
    localparam int FULL_STEPS_PER_REV = 500;
    localparam int RING_HALF_STEPS = 20;
    localparam int RING_FULL_STEPS = 10;
    localparam int FOLLOW_LIMIT = 16;
    localparam int OVERHEAT_DEG_C = 95;
    localparam int BOOST_LIMIT_MA = 4500;

    // Display codes
    localparam logic [3:0] DISPLAY_DOT = 4'hF;
    localparam logic [3:0] DISPLAY_ENABLE_OFF = 4'h8;
    localparam logic [3:0] DISPLAY_FOLLOW = 4'h1;
    localparam logic [3:0] DISPLAY_MOTOR_HOT = 4'hE;

endpackage : stepper_drive_pkg

// ---- hdl/stepper_drive_signal_interface.sv ----
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module stepper_drive_signal_interface
#(
    parameter int READY_DELAY = stepper_drive_pkg::READY_DELAY_CYCLES,
    parameter int STANDSTILL_DELAY = stepper_drive_pkg::STANDSTILL_CYCLES,
    parameter int NOMINAL_MA = 2000
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic stepPulseIn,
    input wire logic directionIn,
    input wire logic stepSizeIn,
    input wire logic boostIn,
    input wire logic current_pwm_in,
    input wire logic enableIn,
    input wire logic monitor_clear_in,
    input wire logic sensorStepIn,
    input wire logic sensorDirIn,
    input wire logic [7:0] motorTempIn,
    input wire logic powerFaultIn,
    output logic following_error_out,
    output logic ringZeroOut,
    output logic motor_overheat_out,
    output logic readyRelayOut,
    output logic stepOut,
    output logic directionOut,
    output logic [12:0] phaseCurrentMa,
    output logic [3:0] displayCode,
    output logic decimalPointOut
);
    import stepper_drive_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic [NSYNC-1:0] syncC;
    logic [7:0] tempA;
    logic [7:0] tempB;
    wire [NSYNC-1:0] rawIn = {powerFaultIn, sensorDirIn, sensorStepIn, monitor_clear_in, enableIn,
                              current_pwm_in, boostIn, stepSizeIn, directionIn, stepPulseIn};

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end
        else
        begin
            syncA <= rawIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // The sensor side holds the temperature word for many cycles, so no handshake
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            tempA <= 8'h00;
            tempB <= 8'h00;
        end
        else
        begin
            tempA <= motorTempIn;
            tempB <= tempA;
        end
    end

    // inputs are active high once synchronised
    wire pulseLvl = syncB[0];
    wire dirLvl = syncB[1];
    wire sizeLvl = syncB[2];
    wire boostLvl = syncB[3];
    wire pwmLvl = syncB[4];
    wire enableLvl = syncB[5];
    wire clearLvl = syncB[6];
    wire sensorStep = syncB[7] & ~syncC[7];
    wire sensorDir = syncB[8];
    wire powerFault = syncB[9];
    wire stepEdge = pulseLvl & ~syncC[0];

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    logic [3:0] ctrl;
    logic wrPending;
    logic [7:0] wrAddr;
    wire addrPhase = hsel & hready & htrans[1];
    wire [7:0] reqAddr = haddr[7:0];
    // Size is ignored: every register is one whole word
    wire writeCtrl = wrPending & (wrAddr == CTRL_OFFSET);
    wire readTake = addrPhase & ~hwrite;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ctrl <= CTRL_RESET;
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
        end
        else
        begin
            wrPending <= addrPhase & hwrite;
            wrAddr <= reqAddr;
            if (writeCtrl)
                ctrl <= hwdata[3:0];
        end
    end

    // No wait states and no error response, so both stay at their reset level
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            hreadyout <= 1'b1;
        else
            hreadyout <= 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    wire reduceOn = ctrl[CTRL_REDUCE_BIT];
    wire dirSwap = ctrl[CTRL_DIR_SWAP_BIT];
    wire stepSwap = ctrl[CTRL_STEP_SWAP_BIT];
    wire monitorOn = ctrl[CTRL_MONITOR_ON_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Power-up readiness
    logic [31:0] upCount;
    logic poweredUp;
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            upCount <= '0;
            poweredUp <= 1'b0;
        end
        else if (!poweredUp)
        begin
            upCount <= upCount + 32'h00000001;
            if (upCount >= 32'(READY_DELAY - 1))
                poweredUp <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step, ring and position
    wire halfMode = sizeLvl ? stepSwap : ~stepSwap;
    wire forward = dirLvl ? dirSwap : ~dirSwap;
    wire [4:0] ringTop = halfMode ? 5'(RING_HALF_STEPS - 1) : 5'(RING_FULL_STEPS - 1);
    wire [9:0] revTop = halfMode ? 10'(HALF_STEPS_PER_REV - 1) : 10'(FULL_STEPS_PER_REV - 1);
    wire stepTake = stepEdge & enableLvl & ~powerFault;
    // A full step counts as two half steps in the following distance
    wire [5:0] stepWeight = halfMode ? 6'h01 : 6'h02;

    logic [4:0] ring;
    logic [9:0] position;
    logic [6:0] follow;
    logic followErr;
    logic [31:0] idleCount;
    logic standstill;
    wire clearReset = clearLvl & standstill;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn || !enableLvl || clearReset)
            ring <= 5'h00;
        else if (stepTake)
        begin
            if (forward)
                ring <= (ring >= ringTop) ? 5'h00 : ring + 5'h01;
            else
                ring <= (ring == 5'h00 || ring > ringTop) ? ringTop : ring - 5'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            position <= 10'h000;
        else if (stepTake)
        begin
            if (forward)
                position <= (position >= revTop) ? 10'h000 : position + 10'h001;
            else
                position <= (position == 10'h000 || position > revTop) ? revTop : position - 10'h001;
        end
    end

    // Commanded minus sensed distance, in half steps, signed
    wire signed [6:0] cmdDelta = stepTake ? (forward ? 7'(stepWeight) : -7'(stepWeight)) : 7'sd0;
    wire signed [6:0] senDelta = sensorStep ? (sensorDir ? 7'sd1 : -7'sd1) : 7'sd0;
    wire signed [6:0] nextFollow = $signed(follow) + cmdDelta - senDelta;
    wire [6:0] followMag = nextFollow[6] ? 7'(-nextFollow) : nextFollow;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn || clearLvl || !monitorOn)
        begin
            follow <= 7'h00;
            if (!resetn || clearReset)
                followErr <= 1'b0;
        end
        else
        begin
            follow <= nextFollow;
            if (followMag > 7'(FOLLOW_LIMIT))
                followErr <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standstill detection and current
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            idleCount <= '0;
            standstill <= 1'b1;
        end
        else if (stepEdge)
        begin
            idleCount <= '0;
            standstill <= 1'b0;
        end
        else if (idleCount >= 32'(STANDSTILL_DELAY - 1))
            standstill <= 1'b1;
        else
            idleCount <= idleCount + 32'h00000001;
    end

    // Heatsink and short faults remove current; following error does not
    wire faultOff = powerFault | ~enableLvl | ~poweredUp;
    wire [12:0] boosted = (2 * NOMINAL_MA > BOOST_LIMIT_MA) ? 13'(BOOST_LIMIT_MA) : 13'(2 * NOMINAL_MA);
    wire [12:0] setCurrent = boostLvl ? boosted : 13'(NOMINAL_MA);
    wire reduceNow = reduceOn & standstill & ~boostLvl & ~clearLvl;
    wire [12:0] next_phaseCurrent = faultOff ? 13'h0000 : !pwmLvl ? 13'h0000 :
                                    reduceNow ? (setCurrent >> 1) : setCurrent;

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    wire hotNow = tempB >= 8'(OVERHEAT_DEG_C);
    wire readyNow = poweredUp & enableLvl & ~powerFault;
    wire [3:0] next_display = !enableLvl ? DISPLAY_ENABLE_OFF : followErr ? DISPLAY_FOLLOW :
                              hotNow ? DISPLAY_MOTOR_HOT : DISPLAY_DOT;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            following_error_out <= 1'b1;
        else
            following_error_out <= ~followErr;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            ringZeroOut <= 1'b1;
        else
            ringZeroOut <= ring != 5'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            motor_overheat_out <= 1'b1;
        else
            motor_overheat_out <= ~hotNow;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            readyRelayOut <= 1'b0;
        else
            readyRelayOut <= readyNow;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            stepOut <= 1'b0;
        else
            stepOut <= stepTake;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            directionOut <= 1'b0;
        else
            directionOut <= forward;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            phaseCurrentMa <= 13'h0000;
        else
            phaseCurrentMa <= next_phaseCurrent;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            displayCode <= DISPLAY_DOT;
        else
            displayCode <= next_display;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            decimalPointOut <= 1'b0;
        else
            decimalPointOut <= readyNow;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered in the data phase
    wire [31:0] statusWord = {24'h000000, powerFault, standstill, boostLvl, halfMode,
                              ring == 5'h00, hotNow, followErr, readyNow};
    wire [31:0] readMux = reqAddr == CTRL_OFFSET ? {28'h0000000, ctrl} :
                          reqAddr == STATUS_OFFSET ? statusWord :
                          reqAddr == POSITION_OFFSET ? {17'h00000, ring, position} : 32'h00000000;
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (readTake)
            hrdata <= readMux;
    end

endmodule : stepper_drive_signal_interface

// ---- bench/step_source.sv ----
`timescale 1ns/10ps
module step_source
(
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [7:0] n,
    input wire logic monitor_clear_in,
    output logic stepPulseIn,
    output logic busy
);
    logic [7:0] left = 8'h0;
    logic [1:0] ph = 2'h0;
    logic level = 1'b0;
    logic run = 1'b0;
    assign stepPulseIn = level;
    assign busy = run;
    // High and low four cycles each, above the three-cycle minimum
    always @(posedge ref_clk)
    begin
        if (go && !run && !monitor_clear_in)
        begin
            left <= n;
            run <= n != 8'h0;
            ph <= 2'h0;
        end
        else if (run)
        begin
            ph <= ph + 2'h1;
            if (ph == 2'h3)
                level <= !level;
            if (ph == 2'h3 && level)
            begin
                left <= left - 8'h1;
                run <= left != 8'h1;
            end
        end
    end
endmodule : step_source

// ---- bench/stepper_drive_properties.sv ----
`timescale 1ns/10ps
module stepper_drive_properties
#(
    parameter int READY_DELAY = 50
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic enableIn,
    input wire logic powerFaultIn,
    input wire logic current_pwm_in,
    input wire logic stepPulseIn,
    input wire logic monitor_clear_in,
    input wire logic [7:0] motorTempIn,
    input wire logic stepOut,
    input wire logic following_error_out,
    input wire logic motor_overheat_out,
    input wire logic readyRelayOut,
    input wire logic [12:0] phaseCurrentMa,
    input wire logic [3:0] displayCode
);
    import stepper_drive_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    int upTime;
    always_ff @(posedge ref_clk)
        upTime <= !resetn ? 0 : upTime + int'(upTime < READY_DELAY);
    // Five cycles cover the two sync stages plus the output register
    sequence s_off; (!enableIn && !powerFaultIn)[*5]; endsequence
    sequence s_fault; (!enableIn || powerFaultIn)[*5]; endsequence
    property p_no_drive; s_fault |-> phaseCurrentMa == 13'h0; endproperty
    a_no_drive: assert property (p_no_drive) else $error("current while off");
    property p_show8; s_off |-> displayCode == DISPLAY_ENABLE_OFF; endproperty
    a_show8: assert property (p_show8) else $error("display not 8");
    property p_not_ready; s_fault |-> !readyRelayOut; endproperty
    a_not_ready: assert property (p_not_ready) else $error("ready while off");
    property p_pwm; (!current_pwm_in)[*5] |-> phaseCurrentMa == 13'h0; endproperty
    a_pwm: assert property (p_pwm) else $error("current with pwm low");
    property p_hot; $stable(motorTempIn)[*5] |-> motor_overheat_out == (motorTempIn < OVERHEAT_DEG_C); endproperty
    a_hot: assert property (p_hot) else $error("overheat output wrong");
    property p_ready; upTime < READY_DELAY - 1 |-> !readyRelayOut; endproperty
    a_ready: assert property (p_ready) else $error("ready too early");
    property p_step; $rose(stepPulseIn) && enableIn && !powerFaultIn |-> ##[2:5] stepOut; endproperty
    a_step: assert property (p_step) else $error("step lost");
    property p_latch; (!monitor_clear_in)[*4] ##0 !following_error_out |=> !following_error_out; endproperty
    a_latch: assert property (p_latch) else $error("error not held");
endmodule : stepper_drive_properties

// ---- bench/tb_stepper_drive_signal_interface.sv ----
`timescale 1ns/10ps
module tb_stepper_drive_signal_interface;
    import stepper_drive_pkg::*;
    localparam int NOM = 3000;
    localparam logic [37:0] FE = 38'h4, RZ = 38'h2, OT = 38'h1, RDY = 38'h8, CUR = 38'h3FFE00;
    logic ref_clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, hsel = 1'b1, follow = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] n = 8'h0, motorTempIn = 8'h19;
    logic hreadyout, hresp, hready, busy, stepPulseIn, directionIn = 1'b0, stepSizeIn = 1'b0;
    logic boostIn = 1'b0, current_pwm_in = 1'b1, enableIn = 1'b1, monitor_clear_in = 1'b0;
    logic sensorStepIn = 1'b0, sensorDirIn = 1'b1, powerFaultIn = 1'b0;
    logic following_error_out, ringZeroOut, motor_overheat_out, readyRelayOut, stepOut;
    logic directionOut, decimalPointOut;
    logic [12:0] phaseCurrentMa;
    logic [3:0] displayCode;
    logic [75:0] q[$];
    logic [75:0] e;
    int mismatches = 0, tests_run = 0;
    event smp;
    wire [37:0] obs = {hrdata[15:0], phaseCurrentMa, displayCode, decimalPointOut, readyRelayOut,
        following_error_out, ringZeroOut, motor_overheat_out};
    assign hready = hreadyout;
    stepper_drive_signal_interface #(.READY_DELAY(50), .STANDSTILL_DELAY(40), .NOMINAL_MA(NOM))
        i_stepper_drive_signal_interface (.*);
    step_source i_step_source (.*);
    initial forever #12.5 ref_clk = !ref_clk;
    // Motor sensor echoes accepted steps only while follow is set
    always @(posedge ref_clk) sensorStepIn <= follow & stepOut;
    always @(posedge ref_clk) sensorDirIn <= directionOut;
    ////////////////////////////////////////
    always @(smp)
        while (q.size() > 0)
        begin
            e = q.pop_front();
            chk(obs & e[75:38], e[37:0]);
        end
    task chk(input logic [37:0] a, b);
        tests_run++;
        if (a !== b)
        begin
            mismatches++;
            $display("[FAIL] %0t %h %h", $time, a, b);
        end
    endtask : chk
    task x(input logic [37:0] m, v);
        q.push_back({m, v});
        ->smp;
    endtask : x
    function logic [37:0] c(input int v);
        return {16'h0, 13'(v), 9'h0};
    endfunction : c
    task wt(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : wt
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
    endtask : bus
    task rd(input logic [7:0] a, input logic [15:0] m, v);
        bus(1'b0, a, 32'h0);
        x({m, 22'h0}, {v, 22'h0});
    endtask : rd
    task steps(input logic [7:0] k);
        n <= k;
        go <= 1'b1;
        wt(2);
        go <= 1'b0;
        for (int i = 0; i < 3000 && busy; i++) @(posedge ref_clk);
        wt(8);
    endtask : steps
    task stop_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    initial
    begin
        wt(30000);
        mismatches++;
        stop_test();
    end
    initial
    begin
        void'($urandom(74));
        wt(20);
        x(38'h3FFFFD, 38'h1E5);
        resetn <= 1'b1;
        wt(30);
        x(RDY | 38'h10, 38'h0);
        wt(40);
        x(RDY | 38'h10 | CUR, c(NOM / 2) | 38'h18);
        boostIn <= 1'b1;
        wt(6);
        x(CUR, c(BOOST_LIMIT_MA));
        boostIn <= 1'b0;
        rd(8'h0, 16'hF, 16'h9);
        bus(1'b1, 8'h0C, $urandom);
        rd(8'h0C, 16'hFFFF, 16'h0);
        steps(8'h10);
        x(FE, FE);
        steps(8'h1);
        x(FE | RDY, RDY);
        wt(50);
        x(FE, 38'h0);
        monitor_clear_in <= 1'b1;
        wt(6);
        x(CUR, c(NOM));
        monitor_clear_in <= 1'b0;
        wt(6);
        x(FE | RZ, FE);
        follow <= 1'b1;
        steps(8'h3);
        enableIn <= 1'b0;
        wt(6);
        x(CUR | RZ | RDY | 38'h1E0, 38'h100);
        enableIn <= 1'b1;
        wt(6);
        steps(8'h1);
        x(RZ, RZ);
        steps(8'h13);
        x(RZ, 38'h0);
        rd(8'h8, 16'h3FF, 16'h28);
        directionIn <= 1'b1;
        steps(8'h29);
        rd(8'h8, 16'h3FF, 16'h3E7);
        stepSizeIn <= 1'b1;
        enableIn <= 1'b0;
        wt(6);
        enableIn <= 1'b1;
        wt(6);
        steps(8'h9);
        x(RZ, RZ);
        steps(8'h1);
        x(RZ, 38'h0);
        bus(1'b1, 8'h0, 32'hD);
        rd(8'h4, 16'h10, 16'h10);
        motorTempIn <= 8'($urandom % 95);
        wt(6);
        x(OT, OT);
        motorTempIn <= 8'(95 + $urandom % 100);
        wt(6);
        x(OT, 38'h0);
        current_pwm_in <= 1'b0;
        wt(6);
        x(CUR, 38'h0);
        current_pwm_in <= 1'b1;
        powerFaultIn <= 1'b1;
        wt(6);
        x(CUR | RDY, 38'h0);
        chk({36'h0, hreadyout, hresp}, 38'h2);
        stop_test();
    end
endmodule : tb_stepper_drive_signal_interface
bind stepper_drive_signal_interface stepper_drive_properties #(.READY_DELAY(READY_DELAY))
    i_stepper_drive_properties (.*);
